// >>> tssro_pkg.sv
// constants for the tile status, security and ring oscillator register bank
// assumes registers are reached by processor-status index, one 32-bit word each
package tssro_pkg;

    // processor-status register indices
    localparam logic [7:0] PS_BOOT_STATE = 8'h03;
    localparam logic [7:0] PS_SECURITY = 8'h05;
    localparam logic [7:0] PS_OSC_CTRL = 8'h06;
    localparam logic [7:0] PS_OSC_COUNT0 = 8'h07;
    localparam logic [7:0] PS_RAM_SIZE = 8'h0C;
    localparam logic [7:0] PS_DBG_STATUS = 8'h10;
    localparam logic [7:0] PS_DBG_PC = 8'h11;
    localparam logic [7:0] PS_DBG_SP = 8'h12;
    localparam logic [7:0] PS_DBG_THREAD = 8'h13;
    localparam logic [7:0] PS_DBG_REGSEL = 8'h14;

    // boot status field positions
    localparam int BOOT_PROC_LSB = 16;
    localparam int BOOT_OVERRIDE_BIT = 8;
    localparam int BOOT_CORE_OFF_BIT = 5;
    localparam int BOOT_NO_POLL_BIT = 4;
    localparam int BOOT_RAM_BIT = 3;
    localparam int BOOT_JTAG_BIT = 2;

    // security field positions and writable bits
    localparam int SEC_WRITE_LOCK_BIT = 31;
    localparam int SEC_GDEBUG_DIS_BIT = 14;
    localparam int SEC_LOCK_ALL_BIT = 12;
    localparam int SEC_SECTOR_LSB = 8;
    localparam int SEC_REDUND_BIT = 7;
    localparam int SEC_BOOT_OTP_BIT = 5;
    localparam int SEC_JTAG_CFG_DIS_BIT = 4;
    localparam int SEC_TAP_DIS_BIT = 0;
    localparam logic [31:0] SEC_MASK = 32'h80005FB1;
    localparam logic [31:0] SEC_RESET = 32'h00000000;

    // oscillator control
    localparam int OSC_CORE_EN_BIT = 1;
    localparam int OSC_PERIPH_EN_BIT = 0;
    localparam logic [1:0] OSC_CTRL_RESET = 2'h0;
    localparam int NUM_OSC = 4;
    localparam int OSC_COUNT_W = 16;
    localparam int OSC_SETTLE_CYCLES = 10;

    // ram size, low two bits reserved
    localparam logic [31:0] RAM_SIZE_BYTES = 32'h00080000;
    localparam logic [31:0] RAM_SIZE_MASK = 32'hFFFFFFFC;

    // debug snapshot fields
    localparam logic [10:0] DBG_STATUS_CAPTURE = 11'h7DF;
    localparam logic [10:0] DBG_STATUS_WRITABLE = 11'h6DF;
    localparam logic [31:0] DBG_RESET = 32'h00000000;
    localparam int DBG_THREAD_W = 8;
    localparam int DBG_REGSEL_W = 5;

endpackage : tssro_pkg

// >>> tssro_osc_if.sv
// bundle between the register bank and the oscillator counters
// assumes both ends run on the same core clock
`timescale 1ns/1ps
`default_nettype none
interface tssro_osc_if;
    import tssro_pkg::*;
    logic [NUM_OSC-1:0] en;
    logic [NUM_OSC-1:0][OSC_COUNT_W-1:0] count;
    modport prod (input en, output count);
    modport cons (output en, input count);
endinterface : tssro_osc_if
`default_nettype wire

// >>> tssro_osc_counters.sv
// counters for the four ring oscillator outputs
// assumes ring outputs arrive from cells that run free of the core clock
`timescale 1ns/1ps
`default_nettype none
module tssro_osc_counters
    import tssro_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [NUM_OSC-1:0] i_ring_osc,
    tssro_osc_if.prod osc
);

    genvar g;
    generate
        for (g = 0; g < NUM_OSC; g++) begin : g_osc
            logic meta_q;
            logic sync_q;
            logic prev_q;
            logic [OSC_COUNT_W-1:0] count_q = '0; // power-up value only, reset never clears it
            logic rise;

            // two-flop synchroniser plus edge history
            always_ff @(posedge i_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                    prev_q <= 1'b0;
                end else begin
                    meta_q <= i_ring_osc[g];
                    sync_q <= meta_q;
                    prev_q <= sync_q;
                end
            end

            assign rise = sync_q & ~prev_q;

            // count kept through system reset, so no reset term
            always_ff @(posedge i_clk) begin
                if (rise && osc.en[g]) begin
                    count_q <= count_q + 1'b1;
                end
            end

            assign osc.count[g] = count_q;
        end
    endgenerate

endmodule : tssro_osc_counters
`default_nettype wire

// >>> tssro_regs.sv
// tile status, security and ring oscillator register bank
// assumes processor-status reads and writes arrive as one-cycle strobes on i_clk
`timescale 1ns/1ps
`default_nettype none
module tssro_regs
    import tssro_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_ps_wr,
    input wire logic i_ps_rd,
    input wire logic [7:0] i_ps_addr,
    input wire logic [31:0] i_ps_wdata,
    output logic [31:0] o_ps_rdata,
    output logic o_ps_rvalid,
    input wire logic [7:0] i_proc_num,
    input wire logic i_boot_mode_override,
    input wire logic i_second_core_off,
    input wire logic i_skip_otp_poll,
    input wire logic i_boot_from_ram,
    input wire logic i_boot_from_jtag,
    input wire logic [1:0] i_boot_pll_mode,
    input wire logic i_otp_sec_valid,
    input wire logic [31:0] i_otp_sec_word,
    input wire logic i_debug_mode,
    input wire logic i_debug_entry,
    input wire logic [10:0] i_thread_status,
    input wire logic [31:0] i_saved_pc,
    input wire logic [31:0] i_saved_sp,
    input wire logic [NUM_OSC-1:0] i_ring_osc,
    output logic o_core_osc_en,
    output logic o_periph_osc_en,
    output logic o_global_debug_dis,
    output logic o_jtag_tap_dis,
    output logic o_otp_lock_all,
    output logic [3:0] o_otp_sector_lock,
    output logic o_otp_redundancy_en,
    output logic o_boot_from_otp,
    output logic o_jtag_cfg_dis,
    output logic [DBG_THREAD_W-1:0] o_dbg_read_thread,
    output logic [DBG_REGSEL_W-1:0] o_dbg_read_reg
);

    tssro_osc_if osc ();

    logic [15:0] boot_meta_q;
    logic [15:0] boot_sync_q;
    logic [31:0] boot_word;
    logic [31:0] sec_q;
    logic [31:0] sec_d;
    logic [1:0] osc_ctrl_q;
    logic [1:0] osc_ctrl_d;
    logic [10:0] dbg_status_q;
    logic [10:0] dbg_status_d;
    logic [31:0] dbg_pc_q;
    logic [31:0] dbg_pc_d;
    logic [31:0] dbg_sp_q;
    logic [31:0] dbg_sp_d;
    logic [DBG_THREAD_W-1:0] dbg_thread_q;
    logic [DBG_THREAD_W-1:0] dbg_thread_d;
    logic [DBG_REGSEL_W-1:0] dbg_regsel_q;
    logic [DBG_REGSEL_W-1:0] dbg_regsel_d;
    logic [31:0] rdata_q;
    logic rvalid_q;

    // oscillator counters on their own synchronised inputs
    tssro_osc_counters u_osc (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_ring_osc(i_ring_osc),
        .osc(osc.prod)
    );

    // boot straps come from pins, so two flops before use
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            boot_meta_q <= 16'h0000;
            boot_sync_q <= 16'h0000;
        end else begin
            boot_meta_q <= {i_proc_num, i_boot_mode_override, i_second_core_off,
                            i_skip_otp_poll, i_boot_from_ram, i_boot_from_jtag,
                            i_boot_pll_mode, 1'b0};
            boot_sync_q <= boot_meta_q;
        end
    end

    // boot status word, reserved bits zero
    assign boot_word = {8'h00, boot_sync_q[15:8], 7'h00,
                        boot_sync_q[7], 2'h0,
                        boot_sync_q[6], boot_sync_q[5],
                        boot_sync_q[4], boot_sync_q[3],
                        boot_sync_q[2:1]};

    // address decode
    wire hit_boot = (i_ps_addr == PS_BOOT_STATE);
    wire hit_sec = (i_ps_addr == PS_SECURITY);
    wire hit_osc_ctrl = (i_ps_addr == PS_OSC_CTRL);
    wire [7:0] osc_rel = i_ps_addr - PS_OSC_COUNT0;
    wire hit_osc_cnt = (osc_rel < 8'(NUM_OSC));
    wire hit_ram = (i_ps_addr == PS_RAM_SIZE);
    wire hit_dbg_st = (i_ps_addr == PS_DBG_STATUS);
    wire hit_dbg_pc = (i_ps_addr == PS_DBG_PC);
    wire hit_dbg_sp = (i_ps_addr == PS_DBG_SP);
    wire hit_dbg_th = (i_ps_addr == PS_DBG_THREAD);
    wire hit_dbg_rs = (i_ps_addr == PS_DBG_REGSEL);

    // write strobes; debug fields need debug mode
    wire dbg_wr = i_ps_wr & i_debug_mode;
    wire wr_sec = i_ps_wr & hit_sec & ~sec_q[SEC_WRITE_LOCK_BIT];
    wire wr_osc = i_ps_wr & hit_osc_ctrl;

    // security: otp copy wins over a software write
    assign sec_d = i_otp_sec_valid ? (i_otp_sec_word & SEC_MASK) :
                   wr_sec ? (i_ps_wdata & SEC_MASK) : sec_q;

    // oscillator enables
    assign osc_ctrl_d = wr_osc ? i_ps_wdata[1:0] : osc_ctrl_q;

    // debug snapshots: capture on entry wins over a write; thread and register select take writes only
    assign dbg_status_d = i_debug_entry ? (i_thread_status & DBG_STATUS_CAPTURE) :
                          (dbg_wr && hit_dbg_st) ?
                          ((dbg_status_q & ~DBG_STATUS_WRITABLE) |
                           (i_ps_wdata[10:0] & DBG_STATUS_WRITABLE)) :
                          dbg_status_q;
    assign dbg_pc_d = i_debug_entry ? i_saved_pc :
                      (dbg_wr && hit_dbg_pc) ? i_ps_wdata : dbg_pc_q;
    assign dbg_sp_d = i_debug_entry ? i_saved_sp :
                      (dbg_wr && hit_dbg_sp) ? i_ps_wdata : dbg_sp_q;
    assign dbg_thread_d = (dbg_wr && hit_dbg_th) ? i_ps_wdata[7:0] : dbg_thread_q;
    assign dbg_regsel_d = (dbg_wr && hit_dbg_rs) ? i_ps_wdata[4:0] : dbg_regsel_q;

    // oscillator enables: tile cell and wire on core, others peripheral
    assign osc.en = {osc_ctrl_q[OSC_PERIPH_EN_BIT], osc_ctrl_q[OSC_PERIPH_EN_BIT],
                     osc_ctrl_q[OSC_CORE_EN_BIT], osc_ctrl_q[OSC_CORE_EN_BIT]};

    // read data selection, unmapped reads return zero
    wire [1:0] osc_idx = osc_rel[1:0];
    wire [31:0] rd_mux =
        ({32{hit_boot}} & boot_word) |
        ({32{hit_sec}} & sec_q) |
        ({32{hit_osc_ctrl}} & {30'h0, osc_ctrl_q}) |
        ({32{hit_osc_cnt}} & {16'h0000, osc.count[osc_idx]}) |
        ({32{hit_ram}} & (RAM_SIZE_BYTES & RAM_SIZE_MASK)) |
        ({32{hit_dbg_st}} & {21'h0, dbg_status_q}) |
        ({32{hit_dbg_pc}} & dbg_pc_q) |
        ({32{hit_dbg_sp}} & dbg_sp_q) |
        ({32{hit_dbg_th}} & {24'h0, dbg_thread_q}) |
        ({32{hit_dbg_rs}} & {27'h0, dbg_regsel_q});

    // control and snapshot registers
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sec_q <= SEC_RESET;
            osc_ctrl_q <= OSC_CTRL_RESET;
            dbg_status_q <= DBG_RESET[10:0];
            dbg_pc_q <= DBG_RESET;
            dbg_sp_q <= DBG_RESET;
            dbg_thread_q <= DBG_RESET[7:0];
            dbg_regsel_q <= DBG_RESET[4:0];
        end else begin
            sec_q <= sec_d;
            osc_ctrl_q <= osc_ctrl_d;
            dbg_status_q <= dbg_status_d;
            dbg_pc_q <= dbg_pc_d;
            dbg_sp_q <= dbg_sp_d;
            dbg_thread_q <= dbg_thread_d;
            dbg_regsel_q <= dbg_regsel_d;
        end
    end

    // read response, one cycle after the strobe
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rdata_q <= 32'h00000000;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= i_ps_rd ? rd_mux : rdata_q;
            rvalid_q <= i_ps_rd;
        end
    end

    // outputs straight from flops
    assign o_ps_rdata = rdata_q;
    assign o_ps_rvalid = rvalid_q;
    assign o_core_osc_en = osc_ctrl_q[OSC_CORE_EN_BIT];
    assign o_periph_osc_en = osc_ctrl_q[OSC_PERIPH_EN_BIT];
    assign o_global_debug_dis = sec_q[SEC_GDEBUG_DIS_BIT];
    assign o_jtag_tap_dis = sec_q[SEC_TAP_DIS_BIT];
    assign o_otp_lock_all = sec_q[SEC_LOCK_ALL_BIT];
    assign o_otp_sector_lock = sec_q[SEC_SECTOR_LSB +: 4];
    assign o_otp_redundancy_en = sec_q[SEC_REDUND_BIT];
    assign o_boot_from_otp = sec_q[SEC_BOOT_OTP_BIT];
    assign o_jtag_cfg_dis = sec_q[SEC_JTAG_CFG_DIS_BIT];
    assign o_dbg_read_thread = dbg_thread_q;
    assign o_dbg_read_reg = dbg_regsel_q;

    // cycles since oscillators were last stopped, for the settle check
    logic [3:0] stop_cnt_q;
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            stop_cnt_q <= 4'h0;
        end else if (osc_ctrl_q != 2'h0) begin
            stop_cnt_q <= 4'h0;
        end else if (stop_cnt_q != 4'hF) begin
            stop_cnt_q <= stop_cnt_q + 4'h1;
        end
    end

    // processor number follows the pins two cycles late
    property p_proc_num;
        @(posedge i_clk) disable iff (i_sys_rst)
        (!$past(i_sys_rst) && !$past(i_sys_rst, 2))
            |-> boot_word[23:16] == $past(i_proc_num, 2);
    endproperty
    a_proc_num: assert property (p_proc_num) else $error("processor number wrong");

    // boot low bits returned on read
    property p_boot_low;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ps_rd && hit_boot) |=> o_ps_rvalid && o_ps_rdata[3:0] == $past(boot_word[3:0]);
    endproperty
    a_boot_low: assert property (p_boot_low) else $error("boot low bits wrong");

    // override, core-off and poll bits track their pins
    property p_boot_flags;
        @(posedge i_clk) disable iff (i_sys_rst)
        (!$past(i_sys_rst) && !$past(i_sys_rst, 2))
            |-> boot_word[8] == $past(i_boot_mode_override, 2)
                && boot_word[5] == $past(i_second_core_off, 2)
                && boot_word[4] == $past(i_skip_otp_poll, 2);
    endproperty
    a_boot_flags: assert property (p_boot_flags) else $error("boot flags wrong");

    // otp copy lands next cycle
    property p_otp_load;
        @(posedge i_clk) disable iff (i_sys_rst)
        i_otp_sec_valid |=> sec_q == ($past(i_otp_sec_word) & SEC_MASK);
    endproperty
    a_otp_load: assert property (p_otp_load) else $error("otp copy not loaded");

    // locked security register ignores writes
    property p_sec_lock;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ps_wr && hit_sec && sec_q[31] && !i_otp_sec_valid) |=> $stable(sec_q);
    endproperty
    a_sec_lock: assert property (p_sec_lock) else $error("locked register changed");

    // oscillator enable bits follow the write
    property p_osc_ctrl;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ps_wr && hit_osc_ctrl) |=> o_core_osc_en == $past(i_ps_wdata[1])
                                      && o_periph_osc_en == $past(i_ps_wdata[0]);
    endproperty
    a_osc_ctrl: assert property (p_osc_ctrl) else $error("osc enable wrong");

    // counter reads have zero upper half
    property p_osc_read;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ps_rd && hit_osc_cnt) |=> o_ps_rdata[31:16] == 16'h0000
            && o_ps_rdata[15:0] == $past(osc.count[osc_idx]);
    endproperty
    a_osc_read: assert property (p_osc_read) else $error("counter read wrong");

    // ram size low bits zero
    property p_ram_size;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ps_rd && hit_ram) |=> o_ps_rdata == (RAM_SIZE_BYTES & RAM_SIZE_MASK);
    endproperty
    a_ram_size: assert property (p_ram_size) else $error("ram size wrong");

    // status capture on debug entry
    property p_status_cap;
        @(posedge i_clk) disable iff (i_sys_rst)
        i_debug_entry |=> dbg_status_q == ($past(i_thread_status) & DBG_STATUS_CAPTURE);
    endproperty
    a_status_cap: assert property (p_status_cap) else $error("status not captured");

    // program counter and stack capture
    property p_pc_cap;
        @(posedge i_clk) disable iff (i_sys_rst)
        i_debug_entry |=> dbg_pc_q == $past(i_saved_pc) && dbg_sp_q == $past(i_saved_sp);
    endproperty
    a_pc_cap: assert property (p_pc_cap) else $error("pc not captured");

    // debug fields hold outside debug mode
    property p_dbg_hold;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ps_wr && !i_debug_mode && !i_debug_entry) |=> $stable(dbg_pc_q)
            && $stable(dbg_sp_q) && $stable(dbg_thread_q) && $stable(dbg_regsel_q);
    endproperty
    a_dbg_hold: assert property (p_dbg_hold) else $error("debug field written");

    // register selector takes five bits in debug mode
    property p_regsel;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ps_wr && i_debug_mode && hit_dbg_rs) |=> o_dbg_read_reg == $past(i_ps_wdata[4:0]);
    endproperty
    a_regsel: assert property (p_regsel) else $error("register select wrong");

    // main scenarios
    property p_cov_locked_write;
        @(posedge i_clk) disable iff (i_sys_rst)
        i_ps_wr && hit_sec && sec_q[31];
    endproperty
    c_locked_write: cover property (p_cov_locked_write);

    property p_cov_settled_read;
        @(posedge i_clk) disable iff (i_sys_rst)
        i_ps_rd && hit_osc_cnt && stop_cnt_q >= 4'(OSC_SETTLE_CYCLES);
    endproperty
    c_settled_read: cover property (p_cov_settled_read);

    property p_cov_entry_read;
        @(posedge i_clk) disable iff (i_sys_rst)
        i_debug_entry ##[1:4] (i_ps_rd && hit_dbg_pc);
    endproperty
    c_entry_read: cover property (p_cov_entry_read);

endmodule : tssro_regs
`default_nettype wire

// >>> tssro_regs_test.sv
// self-checking bench for the tile status, security and oscillator bank
// assumes tssro_pkg compiled first; bench drives every input at falling edges
`timescale 1ns/1ps
`default_nettype none
module tssro_regs_test
    import tssro_pkg::*;
;
    logic i_clk, i_sys_rst, i_ps_wr, i_ps_rd, i_otp_sec_valid, i_debug_mode, i_debug_entry;
    logic i_boot_mode_override, i_second_core_off, i_skip_otp_poll, i_boot_from_ram;
    logic i_boot_from_jtag;
    logic [1:0] i_boot_pll_mode;
    logic [7:0] i_ps_addr, i_proc_num;
    logic [31:0] i_ps_wdata, i_otp_sec_word, i_saved_pc, i_saved_sp, o_ps_rdata;
    logic [10:0] i_thread_status;
    logic [NUM_OSC-1:0] i_ring_osc;
    logic o_ps_rvalid, o_core_osc_en, o_periph_osc_en, o_global_debug_dis, o_jtag_tap_dis;
    logic o_otp_lock_all, o_otp_redundancy_en, o_boot_from_otp, o_jtag_cfg_dis;
    logic [3:0] o_otp_sector_lock;
    logic [DBG_THREAD_W-1:0] o_dbg_read_thread;
    logic [DBG_REGSEL_W-1:0] o_dbg_read_reg;
    logic [9:0] sec_outs;
    int bad_count = 0;
    int total_checks = 0;

    // security outputs gathered msb first: gdebug, tap, all, sectors, redund, otp boot, cfg
    assign sec_outs = {o_global_debug_dis, o_jtag_tap_dis, o_otp_lock_all, o_otp_sector_lock,
        o_otp_redundancy_en, o_boot_from_otp, o_jtag_cfg_dis};

    tssro_regs uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ps_wr(i_ps_wr), .i_ps_rd(i_ps_rd),
        .i_ps_addr(i_ps_addr), .i_ps_wdata(i_ps_wdata), .o_ps_rdata(o_ps_rdata),
        .o_ps_rvalid(o_ps_rvalid), .i_proc_num(i_proc_num),
        .i_boot_mode_override(i_boot_mode_override), .i_second_core_off(i_second_core_off),
        .i_skip_otp_poll(i_skip_otp_poll), .i_boot_from_ram(i_boot_from_ram),
        .i_boot_from_jtag(i_boot_from_jtag), .i_boot_pll_mode(i_boot_pll_mode),
        .i_otp_sec_valid(i_otp_sec_valid), .i_otp_sec_word(i_otp_sec_word),
        .i_debug_mode(i_debug_mode), .i_debug_entry(i_debug_entry),
        .i_thread_status(i_thread_status), .i_saved_pc(i_saved_pc), .i_saved_sp(i_saved_sp),
        .i_ring_osc(i_ring_osc), .o_core_osc_en(o_core_osc_en),
        .o_periph_osc_en(o_periph_osc_en), .o_global_debug_dis(o_global_debug_dis),
        .o_jtag_tap_dis(o_jtag_tap_dis), .o_otp_lock_all(o_otp_lock_all),
        .o_otp_sector_lock(o_otp_sector_lock), .o_otp_redundancy_en(o_otp_redundancy_en),
        .o_boot_from_otp(o_boot_from_otp), .o_jtag_cfg_dis(o_jtag_cfg_dis),
        .o_dbg_read_thread(o_dbg_read_thread), .o_dbg_read_reg(o_dbg_read_reg));

    // 50 ns core clock
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one-cycle write strobe, released at the next falling edge
    task automatic ps_write(input logic [7:0] a, input logic [31:0] d);
        @(negedge i_clk);
        i_ps_wr = 1'b1;
        i_ps_addr = a;
        i_ps_wdata = d;
        @(negedge i_clk);
        i_ps_wr = 1'b0;
    endtask : ps_write

    // one-cycle read strobe, then a bounded wait for the valid pulse
    task automatic ps_read(input logic [7:0] a, output logic [31:0] d);
        int n;
        @(negedge i_clk);
        i_ps_rd = 1'b1;
        i_ps_addr = a;
        @(negedge i_clk);
        i_ps_rd = 1'b0;
        for (n = 0; n < 4 && o_ps_rvalid !== 1'b1; n++) @(negedge i_clk);
        check("rvalid", {31'h0, o_ps_rvalid}, 32'h1);
        d = o_ps_rdata;
    endtask : ps_read

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
        logic [31:0] d;
        ps_read(a, d);
        check(name, d, exp);
    endtask : rd_chk

    task automatic do_reset;
        @(negedge i_clk);
        i_sys_rst = 1'b1;
        repeat (10) @(negedge i_clk);
        i_sys_rst = 1'b0;
    endtask : do_reset

    task automatic read_osc(output logic [3:0][31:0] c);
        for (int i = 0; i < 4; i++) ps_read(PS_OSC_COUNT0 + 8'(i), c[i]);
    endtask : read_osc

    // n slow rising edges on all four ring lines, ending low
    task automatic toggle(input int n);
        repeat (2 * n) begin
            repeat (3) @(negedge i_clk);
            i_ring_osc = ~i_ring_osc;
        end
    endtask : toggle

    task automatic t_reset_vals;
        logic [7:0] idx [7] = '{PS_SECURITY, PS_OSC_CTRL, PS_DBG_STATUS, PS_DBG_PC, PS_DBG_SP,
            PS_DBG_THREAD, PS_DBG_REGSEL};
        for (int i = 0; i < 7; i++) rd_chk(idx[i], 32'h0, "reset value");
        check("outputs at reset", {20'h0, sec_outs, o_core_osc_en, o_periph_osc_en}, 32'h0);
        ps_write(8'h04, 32'hFFFFFFFF);
        rd_chk(8'h04, 32'h0, "unmapped 04");
        ps_write(PS_RAM_SIZE, 32'h0);
        rd_chk(PS_RAM_SIZE, RAM_SIZE_BYTES & RAM_SIZE_MASK, "ram size");
    endtask : t_reset_vals

    task automatic t_boot;
        logic [14:0] pins [2] = '{15'b10100101_1_0_1_0_1_10, 15'b01011010_0_1_0_1_0_01};
        logic [31:0] exp [2] = '{32'h00A50116, 32'h005A0029};
        for (int i = 0; i < 2; i++) begin
            @(negedge i_clk);
            {i_proc_num, i_boot_mode_override, i_second_core_off, i_skip_otp_poll,
                i_boot_from_ram, i_boot_from_jtag, i_boot_pll_mode} = pins[i];
            repeat (3) @(negedge i_clk);
            rd_chk(PS_BOOT_STATE, exp[i], "boot status");
        end
        ps_write(PS_BOOT_STATE, 32'h0);
        rd_chk(PS_BOOT_STATE, exp[1], "boot status write");
    endtask : t_boot

    task automatic t_security;
        ps_write(PS_SECURITY, 32'h00005FB1);
        check("sec outputs all", {22'h0, sec_outs}, 32'h3FF);
        ps_write(PS_SECURITY, 32'hFFFFFFFF);
        rd_chk(PS_SECURITY, 32'h80005FB1, "sec reserved");
        ps_write(PS_SECURITY, 32'h0);
        rd_chk(PS_SECURITY, 32'h80005FB1, "sec locked");
        @(negedge i_clk);
        i_otp_sec_valid = 1'b1;
        i_otp_sec_word = 32'h00001230;
        @(negedge i_clk);
        i_otp_sec_valid = 1'b0;
        rd_chk(PS_SECURITY, 32'h00001230, "sec otp copy");
        check("sec outputs otp", {22'h0, sec_outs}, 32'h093);
        ps_write(PS_SECURITY, 32'h00004001);
        check("sec outputs sw", {22'h0, sec_outs}, 32'h300);
    endtask : t_security

    task automatic t_osc(input logic [1:0] ctrl, input int n, input logic [3:0] moved);
        logic [3:0][31:0] c1, c2;
        // baseline taken while still stopped
        read_osc(c1);
        ps_write(PS_OSC_CTRL, {30'h0, ctrl});
        check("osc enables", {30'h0, o_core_osc_en, o_periph_osc_en}, {30'h0, ctrl});
        toggle(n);
        repeat (4) @(negedge i_clk);
        ps_write(PS_OSC_CTRL, 32'h0);
        // settle after stop before reading counts
        repeat (OSC_SETTLE_CYCLES) @(negedge i_clk);
        read_osc(c2);
        for (int i = 0; i < 4; i++) begin
            check("osc upper", {16'h0, c2[i][31:16]}, 32'h0);
            check("osc delta", {16'h0, c2[i][15:0] - c1[i][15:0]},
                moved[i] ? 32'(n) : 32'h0);
        end
    endtask : t_osc

    task automatic t_reset_keep;
        logic [3:0][31:0] c1, c2;
        read_osc(c1);
        ps_write(PS_OSC_CTRL, 32'hFFFFFFFF);
        rd_chk(PS_OSC_CTRL, 32'h3, "osc ctrl reserved");
        do_reset;
        rd_chk(PS_OSC_CTRL, 32'h0, "osc ctrl after reset");
        read_osc(c2);
        for (int i = 0; i < 4; i++) check("osc kept", c2[i], c1[i]);
    endtask : t_reset_keep

    task automatic t_debug;
        ps_write(PS_DBG_PC, 32'h12345678);
        rd_chk(PS_DBG_PC, 32'h0, "dbg write outside");
        @(negedge i_clk);
        i_debug_entry = 1'b1;
        @(negedge i_clk);
        i_debug_entry = 1'b0;
        rd_chk(PS_DBG_STATUS, 32'h000007DF, "dbg status");
        rd_chk(PS_DBG_PC, 32'hCAFEF00D, "dbg pc");
        rd_chk(PS_DBG_SP, 32'h0BADBEEF, "dbg sp");
        i_debug_mode = 1'b1;
        ps_write(PS_DBG_STATUS, 32'h0);
        rd_chk(PS_DBG_STATUS, 32'h00000100, "dbg status write");
        ps_write(PS_DBG_SP, 32'h13572468);
        rd_chk(PS_DBG_SP, 32'h13572468, "dbg sp write");
        ps_write(PS_DBG_THREAD, 32'hFFFFFFFF);
        ps_write(PS_DBG_REGSEL, 32'hFFFFFFFF);
        rd_chk(PS_DBG_THREAD, 32'h000000FF, "dbg thread");
        rd_chk(PS_DBG_REGSEL, 32'h0000001F, "dbg regsel");
        check("dbg operand outs", {19'h0, o_dbg_read_thread, o_dbg_read_reg}, 32'h1FFF);
        i_debug_mode = 1'b0;
        ps_write(PS_DBG_THREAD, 32'h0);
        rd_chk(PS_DBG_THREAD, 32'h000000FF, "dbg thread locked");
    endtask : t_debug

    // watchdog against a hung handshake
    initial begin
        repeat (6000) @(posedge i_clk);
        bad_count++;
        conclude();
    end

    // main sequence
    initial begin
        {i_ps_wr, i_ps_rd, i_otp_sec_valid, i_debug_mode, i_debug_entry} = 5'h0;
        {i_proc_num, i_boot_mode_override, i_second_core_off, i_skip_otp_poll} = 11'h0;
        {i_boot_from_ram, i_boot_from_jtag, i_boot_pll_mode} = 4'h0;
        i_ps_addr = 8'h00;
        i_ps_wdata = 32'h0;
        i_otp_sec_word = 32'h0;
        i_thread_status = 11'h7FF;
        i_saved_pc = 32'hCAFEF00D;
        i_saved_sp = 32'h0BADBEEF;
        i_ring_osc = 4'h0;
        i_sys_rst = 1'b1;
        repeat (10) @(negedge i_clk);
        i_sys_rst = 1'b0;
        t_reset_vals();
        t_boot();
        t_security();
        t_osc(2'h1, 5, 4'b1100);
        t_osc(2'h2, 3, 4'b0011);
        t_reset_keep();
        t_debug();
        conclude();
    end
endmodule : tssro_regs_test
`default_nettype wire
